//--- include/cpc_regs.svh
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// pixel, correction and calibration accumulator widths
`define CPC_PIX_W 12
`define CPC_COEF_W 12
`define CPC_ACC_W 40
`define CPC_PAIR_W 32
`define CPC_SUM_W 14
// largest pixel code, used for clipping
`define CPC_PIX_MAX 12'hfff
// built-in correction value loaded at power-up
`define CPC_COEF_DEFAULT 12'h000
// number of frames gathered by one calibration
`define CPC_CAL_FRAMES 2'h3
// entries of the output buffer
`define CPC_BUF_DEPTH 2

`endif

//--- include/cpc_pkg.sv
package cpc_pkg;

	// calibration sequencer states, one-hot
	typedef enum logic [3:0]
	{
		cpc_st_idle = 4'h1,
		cpc_st_wait = 4'h2,
		cpc_st_gather = 4'h4,
		cpc_st_solve = 4'h8
	} cpc_state_t;

	// values of checker_fix_mode
	typedef enum logic
	{
		calibration_off = 1'h0,
		single_calibration = 1'h1
	} cpc_mode_t;

endpackage

//--- rtl/cpc_buf.sv
`timescale 1ns/1ps
`include "cpc_regs.svh"

// small fifo between the corrector and the image output
module cpc_buf #(
	parameter int WIDTH = 15,
	parameter int DEPTH = `CPC_BUF_DEPTH
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage entries
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d; // write index
	logic [AW-1:0] rd_q, rd_d; // read index
	logic [AW:0] cnt_q, cnt_d; // words held
	logic push, pop;

	// full and empty come straight from the count
	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// next indices, count and storage
	always_comb
	begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		for (int i = 0; i < DEPTH; i++)
		begin
			mem_d[i] = mem_q[i];
		end
		if (push)
		begin
			mem_d[wr_q] = in_data_i;
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop)
		begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		// simultaneous push and pop keep the count
		if (push && !pop)
		begin
			cnt_d = cnt_q + 1'b1;
		end
		else if (pop && !push)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// register stage
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_q[i] <= '0;
			end
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	// a stalled word stays put until taken
	a_buf_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("buffered word changed while stalled");

endmodule

//--- rtl/cpc_top.sv
// How it works
// - power-up loads built-in default correction value
// - active correction applied to every pixel
// - single calibration gathers next three frames
// - after three frames, store value, mode off
// - frames may come single-shot or continuous
// - restart discards unsaved values, defaults return
// - loading a user set restores its value
// - stored value stays until recalibrated or loaded
`timescale 1ns/1ps
`include "cpc_regs.svh"

module cpc_top (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic pix_valid_i,
	output logic pix_ready_o,
	input wire logic [`CPC_PIX_W-1:0] pix_data_i,
	input wire logic pix_sof_i,
	input wire logic pix_sol_i,
	input wire logic pix_eof_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [`CPC_PIX_W-1:0] out_data_o,
	output logic out_sof_o,
	output logic out_sol_o,
	output logic out_eof_o,
	input wire logic mode_wr_i,
	input wire logic mode_wr_val_i,
	output logic checker_fix_mode_o,
	input wire logic set_load_i,
	input wire logic [`CPC_COEF_W-1:0] set_coef_i,
	output logic [`CPC_COEF_W-1:0] coef_o
);
	localparam int BW = `CPC_PIX_W + 3; // pixel plus three markers

	cpc_pkg::cpc_state_t st_q, st_d; // calibration sequencer
	logic [1:0] frm_q, frm_d; // frames finished in calibration
	logic signed [`CPC_ACC_W-1:0] acc_q, acc_d; // sum of pair differences
	logic [`CPC_PAIR_W-1:0] pairs_q, pairs_d; // pairs summed
	logic [`CPC_PIX_W-1:0] prev_q, prev_d; // last even-phase pixel
	logic signed [`CPC_COEF_W-1:0] coef_q, coef_d; // active correction
	logic row_q, row_d; // row parity of the last pixel
	logic col_q, col_d; // column parity of the next pixel
	logic in_fire; // pixel accepted this cycle
	logic row_cur, col_cur, par; // phase of the present pixel
	logic take; // present pixel feeds calibration
	logic signed [`CPC_PIX_W:0] diff; // odd minus even
	logic signed [`CPC_SUM_W-1:0] offs, sum; // signed offset and result
	logic [`CPC_PIX_W-1:0] corr; // clipped corrected pixel
	logic signed [`CPC_ACC_W-1:0] solved; // averaged half difference
	logic [BW-1:0] buf_out;

	// index of the highest set bit, zero for zero
	function automatic logic [5:0] cpc_msb(input logic [`CPC_PAIR_W-1:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < `CPC_PAIR_W; i++)
		begin
			if (v[i])
			begin
				r = 6'(i);
			end
		end
		return r;
	endfunction

	// position parity of the pixel on the input
	assign row_cur = pix_sof_i ? 1'b0 : (pix_sol_i ? ~row_q : row_q);
	assign col_cur = (pix_sof_i || pix_sol_i) ? 1'b0 : col_q;
	assign par = row_cur ^ col_cur;
	assign in_fire = pix_valid_i && pix_ready_o;

	// even phase is raised by the value, odd phase lowered
	always_comb
	begin
		offs = `CPC_SUM_W'(coef_q);
		if (par)
		begin
			offs = -`CPC_SUM_W'(coef_q);
		end
		sum = $signed({2'h0, pix_data_i}) + offs;
		if (sum < 0)
		begin
			corr = '0;
		end
		else if (sum > $signed({2'h0, `CPC_PIX_MAX}))
		begin
			corr = `CPC_PIX_MAX;
		end
		else
		begin
			corr = sum[`CPC_PIX_W-1:0];
		end
	end

	// position tracker, next values
	always_comb
	begin
		row_d = row_q;
		col_d = col_q;
		if (in_fire)
		begin
			row_d = row_cur;
			col_d = ~col_cur;
		end
	end

	// position tracker, registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			row_q <= 1'b0;
			col_q <= 1'b0;
		end
		else
		begin
			row_q <= row_d;
			col_q <= col_d;
		end
	end

	// calibration gathers from the first frame start after the request
	assign take = in_fire && ((st_q == cpc_pkg::cpc_st_gather)
		|| ((st_q == cpc_pkg::cpc_st_wait) && pix_sof_i));
	assign diff = $signed({1'b0, pix_data_i}) - $signed({1'b0, prev_q});
	// sum of pair differences shifted right by one more than the highest set bit of the pair count
	assign solved = acc_q >>> (cpc_msb(pairs_q) + 6'h01);

	// sequencer and correction value, next values
	always_comb
	begin
		st_d = st_q;
		frm_d = frm_q;
		acc_d = acc_q;
		pairs_d = pairs_q;
		prev_d = prev_q;
		coef_d = coef_q;
		if (take)
		begin
			if (!par)
			begin
				prev_d = pix_data_i;
			end
			else
			begin
				acc_d = acc_q + `CPC_ACC_W'(diff);
				pairs_d = pairs_q + 1'b1;
			end
		end
		case (st_q)
			cpc_pkg::cpc_st_idle:
			begin
				frm_d = 2'h0;
				acc_d = '0;
				pairs_d = '0;
				if (mode_wr_i && mode_wr_val_i == cpc_pkg::single_calibration)
				begin
					st_d = cpc_pkg::cpc_st_wait;
				end
			end
			cpc_pkg::cpc_st_wait:
			begin
				// frame start already counted in take above
				if (take)
				begin
					st_d = cpc_pkg::cpc_st_gather;
				end
			end
			cpc_pkg::cpc_st_gather:
			begin
				// frames may arrive with any gap between them
				if (in_fire && pix_eof_i)
				begin
					frm_d = frm_q + 2'h1;
					if (frm_q == `CPC_CAL_FRAMES - 2'h1)
					begin
						st_d = cpc_pkg::cpc_st_solve;
					end
				end
			end
			cpc_pkg::cpc_st_solve:
			begin
				if (pairs_q != '0)
				begin
					coef_d = solved[`CPC_COEF_W-1:0];
				end
				st_d = cpc_pkg::cpc_st_idle;
			end
			default:
			begin
				st_d = cpc_pkg::cpc_st_idle;
			end
		endcase
		// writing off abandons a calibration still waiting or gathering; a solve in progress still stores
		if (mode_wr_i && mode_wr_val_i == cpc_pkg::calibration_off
			&& st_q != cpc_pkg::cpc_st_solve)
		begin
			st_d = cpc_pkg::cpc_st_idle;
		end
		// a loaded user set replaces the value, a finishing solve wins
		if (set_load_i && st_q != cpc_pkg::cpc_st_solve)
		begin
			coef_d = set_coef_i;
		end
	end

	// sequencer and correction value, registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= cpc_pkg::cpc_st_idle;
			frm_q <= 2'h0;
			acc_q <= '0;
			pairs_q <= '0;
			prev_q <= '0;
			coef_q <= `CPC_COEF_DEFAULT;
		end
		else
		begin
			st_q <= st_d;
			frm_q <= frm_d;
			acc_q <= acc_d;
			pairs_q <= pairs_d;
			prev_q <= prev_d;
			coef_q <= coef_d;
		end
	end

	// mode reads back single until the solve is written
	assign checker_fix_mode_o = (st_q == cpc_pkg::cpc_st_idle)
		? cpc_pkg::calibration_off : cpc_pkg::single_calibration;
	assign coef_o = coef_q;

	// two-entry buffer absorbs a stall on the output
	cpc_buf #(
		.WIDTH(BW),
		.DEPTH(`CPC_BUF_DEPTH)
	) u_buf (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(pix_valid_i),
		.in_ready_o(pix_ready_o),
		.in_data_i({pix_eof_i, pix_sol_i, pix_sof_i, corr}),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(buf_out)
	);
	assign out_data_o = buf_out[`CPC_PIX_W-1:0];
	assign out_sof_o = buf_out[`CPC_PIX_W];
	assign out_sol_o = buf_out[`CPC_PIX_W+1];
	assign out_eof_o = buf_out[`CPC_PIX_W+2];

	a_boot_default: assert property (@(posedge mclk_i)
		$fell(sys_rst_i) |-> coef_o == `CPC_COEF_DEFAULT)
		else $error("correction not default after reset");
	a_restart_mode_off: assert property (@(posedge mclk_i)
		$fell(sys_rst_i) |-> checker_fix_mode_o == cpc_pkg::calibration_off)
		else $error("mode not off after reset");
	a_zero_passes: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		in_fire && coef_q == '0 |-> corr == pix_data_i)
		else $error("zero correction altered a pixel");
	a_even_raised: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		in_fire && !par && !coef_q[`CPC_COEF_W-1] |-> corr >= pix_data_i)
		else $error("even pixel not raised");
	a_three_frames: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q == cpc_pkg::cpc_st_solve |-> frm_q == `CPC_CAL_FRAMES)
		else $error("solve without three frames");
	a_solve_stores: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q == cpc_pkg::cpc_st_solve && pairs_q != '0
		|=> checker_fix_mode_o == cpc_pkg::calibration_off
		&& coef_q == $past(solved[`CPC_COEF_W-1:0]))
		else $error("calibration result not stored or mode not off");
	a_gap_waits: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q == cpc_pkg::cpc_st_gather && !(in_fire && pix_eof_i) && !mode_wr_i
		|=> st_q == cpc_pkg::cpc_st_gather)
		else $error("gather left without frame end");
	a_set_restore: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		set_load_i && st_q != cpc_pkg::cpc_st_solve |=> coef_o == $past(set_coef_i))
		else $error("user set value not restored");
	a_coef_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!set_load_i && st_q != cpc_pkg::cpc_st_solve |=> $stable(coef_o))
		else $error("correction changed without cause");
	a_mode_poll: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		mode_wr_i && mode_wr_val_i && st_q == cpc_pkg::cpc_st_idle
		|=> checker_fix_mode_o == cpc_pkg::single_calibration)
		else $error("mode not single after request");

endmodule

//--- tb/cpc_sensor_model.sv
`timescale 1ns/1ps
`include "cpc_regs.svh"

// sensor side: sends frames, gathers corrected words
module cpc_sensor_model (
	input wire logic mclk_i,
	input wire logic pix_ready_i,
	output logic pix_valid_o,
	output logic [`CPC_PIX_W-1:0] pix_data_o,
	output logic pix_sof_o,
	output logic pix_sol_o,
	output logic pix_eof_o,
	input wire logic out_valid_i,
	input wire logic out_ready_i,
	input wire logic [`CPC_PIX_W-1:0] out_data_i,
	input wire logic out_sof_i,
	input wire logic out_sol_i,
	input wire logic out_eof_i
);
	logic [`CPC_PIX_W-1:0] got_q[$]; // words taken at the output
	logic [2:0] got_m[$]; // markers taken at the output, eof sol sof
	logic [2:0] sent_m[$]; // markers accepted at the input, same order

	initial
	begin
		pix_valid_o = 1'b0;
		pix_data_o = 12'h5a5;
		pix_sof_o = 1'b0;
		pix_sol_o = 1'b0;
		pix_eof_o = 1'b0;
	end

	// f one-line frames of n pixels, gapless; even lighting, odd columns offset
	task automatic send(input int f, input int n, input logic [11:0] ev, od);
		int k;
		@(posedge mclk_i);
		#1;
		for (k = 0; k < f * n; k++)
		begin
			pix_valid_o = 1'b1;
			pix_data_o = (k % 2) ? od : ev;
			pix_sof_o = (k % n) == 0;
			pix_eof_o = (k % n) == n - 1;
			@(posedge mclk_i);
			while (pix_ready_i !== 1'b1)
				@(posedge mclk_i);
			#1;
		end
		// released lines show junk, not the last word
		pix_valid_o = 1'b0;
		pix_data_o = ~pix_data_o;
		pix_sof_o = 1'b0;
		pix_eof_o = 1'b0;
	endtask

	// one frame of two lines of two pixels; the value follows the pixel's phase
	task automatic send_grid(input logic [11:0] ev, od);
		int k;
		@(posedge mclk_i);
		#1;
		for (k = 0; k < 4; k++)
		begin
			pix_valid_o = 1'b1;
			pix_data_o = ((k / 2) % 2 != k % 2) ? od : ev;
			pix_sof_o = k == 0;
			pix_sol_o = k == 2;
			pix_eof_o = k == 3;
			@(posedge mclk_i);
			while (pix_ready_i !== 1'b1)
				@(posedge mclk_i);
			#1;
		end
		pix_valid_o = 1'b0;
		pix_data_o = ~pix_data_o;
		pix_sof_o = 1'b0;
		pix_sol_o = 1'b0;
		pix_eof_o = 1'b0;
	endtask

	// collect each word handed over, and the markers sent with each input
	always @(posedge mclk_i)
	begin
		if (out_valid_i === 1'b1 && out_ready_i === 1'b1)
		begin
			got_q.push_back(out_data_i);
			got_m.push_back({out_eof_i, out_sol_i, out_sof_i});
		end
		if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1)
			sent_m.push_back({pix_eof_o, pix_sol_o, pix_sof_o});
	end
endmodule

//--- tb/cpc_top_tb.sv
`timescale 1ns/1ps
`include "cpc_regs.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module cpc_top_tb;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic pix_valid, pix_ready, sof, sol, eof, out_valid, out_sof, out_sol, out_eof;
	logic [11:0] pix_data, out_data, coef, set_coef = 12'h000;
	logic out_ready = 1'b1;
	logic mode_wr = 1'b0;
	logic mode_val = 1'b0;
	logic set_load = 1'b0;
	logic mode;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #2.5 mclk_i = ~mclk_i; // 200 MHz

	cpc_top i_cpc_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pix_valid_i(pix_valid),
		.pix_ready_o(pix_ready), .pix_data_i(pix_data), .pix_sof_i(sof), .pix_sol_i(sol),
		.pix_eof_i(eof), .out_valid_o(out_valid), .out_ready_i(out_ready),
		.out_data_o(out_data), .out_sof_o(out_sof), .out_sol_o(out_sol), .out_eof_o(out_eof),
		.mode_wr_i(mode_wr), .mode_wr_val_i(mode_val), .checker_fix_mode_o(mode),
		.set_load_i(set_load), .set_coef_i(set_coef), .coef_o(coef));

	cpc_sensor_model i_sensor (.mclk_i(mclk_i), .pix_ready_i(pix_ready),
		.pix_valid_o(pix_valid), .pix_data_o(pix_data), .pix_sof_o(sof), .pix_sol_o(sol),
		.pix_eof_o(eof), .out_valid_i(out_valid), .out_ready_i(out_ready),
		.out_data_i(out_data), .out_sof_i(out_sof), .out_sol_i(out_sol),
		.out_eof_i(out_eof));

	// ends the run with the verdict
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			test_done();
		end
	end

	// two-cycle reset, then idle values
	task automatic t_reset();
		@(posedge mclk_i);
		#1;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		`CHK(coef, 12'h000)
		`CHK(mode, 1'b0)
		`CHK(out_valid, 1'b0)
		`CHK(pix_ready, 1'b1)
		$display("reset test done");
	endtask

	// n words expected: even +c, odd -c, clipped
	task automatic chk_out(input int n, input int ev, od, c);
		int k, v;
		logic [11:0] g;
		logic [2:0] gm, em;
		for (k = 0; k < 50 && i_sensor.got_q.size() < n; k++)
			@(posedge mclk_i);
		for (k = 0; k < n; k++)
		begin
			v = (k % 2) ? od - c : ev + c;
			v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
			if (i_sensor.got_q.size() == 0 || i_sensor.sent_m.size() == 0)
				`CHK(1'b0, 1'b1)
			else
			begin
				// pop once, so a mismatch report cannot take a second word
				g = i_sensor.got_q.pop_front();
				gm = i_sensor.got_m.pop_front();
				em = i_sensor.sent_m.pop_front();
				`CHK(g, v[11:0])
				`CHK(gm, em)
			end
		end
	endtask

	// one-cycle write of the mode, readback next cycle
	task automatic wr_mode(input logic v);
		@(posedge mclk_i);
		#1;
		mode_wr = 1'b1;
		mode_val = v;
		@(posedge mclk_i);
		#1;
		mode_wr = 1'b0;
	endtask

	// wait bounded for the end of calibration
	task automatic wait_cal(input logic [11:0] c);
		int k;
		`CHK(mode, 1'b1)
		for (k = 0; k < 20 && mode !== 1'b0; k++)
		begin
			@(posedge mclk_i);
			#1;
		end
		`CHK(k, 1)
		`CHK(mode, 1'b0)
		`CHK(coef, c)
	endtask

	// one-cycle load of a user set value, active next cycle
	task automatic load_set(input logic [11:0] v);
		@(posedge mclk_i);
		#1;
		set_load = 1'b1;
		set_coef = v;
		@(posedge mclk_i);
		#1;
		set_load = 1'b0;
		`CHK(coef, v)
	endtask

	// user set load, clipping and a stalled receiver
	task automatic t_user_set();
		load_set(12'h005);
		out_ready = 1'b0;
		fork
			i_sensor.send(1, 4, 12'hffe, 12'h003);
			begin
				repeat (8) @(posedge mclk_i);
				#1;
				`CHK(pix_ready, 1'b0)
				`CHK(out_valid, 1'b1)
				out_ready = 1'b1;
			end
		join
		chk_out(4, 'hffe, 3, 5);
		$display("user set test done");
	endtask

	// single-shot frames with gaps, then gapless frames
	task automatic t_cal();
		wr_mode(1'b1);
		`CHK(mode, 1'b1)
		// gaps before each frame, so the last one ends right before the solve
		repeat (3)
		begin
			repeat (5) @(posedge mclk_i);
			i_sensor.send(1, 2, 12'h064, 12'h06c);
		end
		wait_cal(12'h006);
		chk_out(6, 100, 108, 5);
		i_sensor.send(1, 2, 12'h064, 12'h06c);
		chk_out(2, 100, 108, 6);
		// host reruns after a lighting change
		wr_mode(1'b1);
		wr_mode(1'b1);
		i_sensor.send(3, 2, 12'h06c, 12'h064);
		wait_cal(12'hffa);
		chk_out(6, 108, 100, 6);
		$display("calibration test done");
	endtask

	// abort keeps the stored value
	task automatic t_abort();
		wr_mode(1'b1);
		i_sensor.send(1, 2, 12'h064, 12'h080);
		wr_mode(1'b0);
		`CHK(mode, 1'b0)
		`CHK(coef, 12'hffa)
		chk_out(2, 100, 128, -6);
		$display("abort test done");
	endtask

	// after a restart the default passes pixels, then a two-line frame
	task automatic t_restart();
		i_sensor.send(1, 2, 12'h064, 12'h06c);
		chk_out(2, 100, 108, 0);
		load_set(12'h003);
		i_sensor.send_grid(12'h064, 12'h0c8);
		chk_out(2, 100, 200, 3);
		chk_out(2, 200, 100, -3);
		$display("restart test done");
	endtask

	initial
	begin
		t_reset();
		t_user_set();
		t_cal();
		t_abort();
		t_reset();
		t_restart();
		test_done();
	end
endmodule
